// ==== src/trmc_pkg.sv ====
// Package for the timer run and mode control block: register map, field
// positions, reset values and the bus carrier structs.
// Assumes a single 125 MHz clock and an AXI4-Lite master with 32-bit data.
package trmc_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register byte offsets
  localparam logic [AXI_ADDR_W-1:0] OFS_RUN = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_CMP0 = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFS_CMP1 = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] OFS_CAP0_LO = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] OFS_CAP0_HI = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] OFS_CAP1_LO = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] OFS_CAP1_HI = 8'h1c;
  localparam logic [AXI_ADDR_W-1:0] OFS_COUNT = 8'h20;
  localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_MASK = 8'h28;

  // ==========================================================================
  // Run register fields
  localparam int RUN_COUNTER_BIT = 0;
  localparam int RUN_PRESCALER_BIT = 2;
  localparam int RUN_IDLE_BIT = 3;
  localparam int RUN_SPARE_BIT = 6;
  localparam int RUN_DBUF_BIT = 7;
  localparam logic [7:0] RUN_RESET = 8'h00;

  // ==========================================================================
  // Mode register fields
  localparam int MODE_SWCAP_BIT = 0;
  localparam int MODE_CLK_LO = 1;
  localparam int MODE_CLEAR_BIT = 3;
  localparam int MODE_CAP_LO = 4;
  localparam logic [7:0] MODE_RESET = 8'h20;
  localparam logic [7:0] MODE_KEEP_MASK = 8'h3e;

  // ==========================================================================
  // Clock sources, capture triggers and interrupt events
  localparam logic [1:0] CLK_EXT = 2'h0;
  localparam logic [1:0] CLK_DIV1 = 2'h1;
  localparam logic [1:0] CLK_DIV4 = 2'h2;
  localparam logic [1:0] CLK_DIV16 = 2'h3;
  localparam logic [1:0] CAP_OFF = 2'h0;
  localparam logic [1:0] CAP_IN0_IN1 = 2'h1;
  localparam logic [1:0] CAP_IN0_BOTH = 2'h2;
  localparam logic [1:0] CAP_OTHER = 2'h3;
  localparam int PRESCALE_W = 4;
  localparam logic [PRESCALE_W-1:0] DIV4_MASK = 4'h3;
  localparam logic [PRESCALE_W-1:0] DIV16_MASK = 4'hf;
  localparam int NUM_EVENTS = 4;
  localparam int EV_CMP0 = 0;
  localparam int EV_CMP1 = 1;
  localparam int EV_CAP0 = 2;
  localparam int EV_CAP1 = 3;

  // ==========================================================================
  // Bus carriers
  typedef struct packed {
    logic awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [AXI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic rready;
  } trmc_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } trmc_axil_rsp_t;

endpackage

// ==== src/trmc_timer.sv ====
// Timer channel with run control, mode control, compare and capture logic,
// reached by software over an AXI4-Lite slave port.
// Assumes all inputs are synchronous to clk_i and one master at a time.
//
// How it works
// R1 - Run bit clear stops and zeroes counter.
// R2 - Idle bit chooses halt or run in idle.
// R3 - Run bits 1, 4, 5 carry no meaning.
// R4 - Clock field picks pin or prescaler taps.
// R5 - Clear enable zeroes counter on compare-1 match.
// R6 - Trigger 00 disables hardware captures.
// R7 - Trigger 01: input 0 and 1 rising.
// R8 - Trigger 10: input 0 rising and falling.
// R9 - Trigger 11: other timer rising and falling.
// R10 - Writing 0 to capture bit latches counter.
// R11 - Software writes zeros to mode top bits.
// R12 - Prescaler run bit independent of counter run.
// R13 - Interval mode: periodic compare-1 interrupt.
// R14 - Software picks prescaler tap, capture off.
// R15 - Software disables flip-flop toggle triggers.
// R16 - Counter equal to compare raises interrupt.
// R17 - Low-byte read blocks capture until high read.
// R18 - Software keeps prescaler running for capture.
// R19 - Double buffer defers compare-0 write to clear.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module trmc_timer #(
  parameter int COUNT_W = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire trmc_pkg::trmc_axil_req_t axi_req_i,
  output trmc_pkg::trmc_axil_rsp_t axi_rsp_o,
  input wire logic external_input_0_i,
  input wire logic external_input_1_i,
  input wire logic other_timer_flipflop_out_i,
  input wire logic idle_i,
  output logic compare0_interrupt_o,
  output logic compare1_interrupt_o,
  output logic irq_o
);
  import trmc_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic rose(input logic prev, input logic cur);
    rose = ~prev & cur;
  endfunction

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  // ==========================================================================
  // Register state
  logic [7:0] run_reg;
  logic [7:0] mode_reg;
  logic [COUNT_W-1:0] compare_register_0;
  logic [COUNT_W-1:0] compare0_buffer;
  logic [COUNT_W-1:0] compare_register_1;
  logic [COUNT_W-1:0] capture_register_0;
  logic [COUNT_W-1:0] capture_register_1;
  logic [COUNT_W-1:0] up_counter;
  logic [NUM_EVENTS-1:0] irq_status;
  logic [NUM_EVENTS-1:0] irq_mask;
  logic cap0_locked;
  logic cap1_locked;
  logic [PRESCALE_W-1:0] prescaler;
  logic in0_prev;
  logic in1_prev;
  logic other_prev;

  // ==========================================================================
  // Bus slave
  logic aw_got;
  logic w_got;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [AXI_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [AXI_DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic do_write;
  logic do_read;
  logic wr_known;
  logic rd_known;
  logic [AXI_DATA_W-1:0] next_rdata;

  assign do_write = aw_got & w_got & ~bvalid;
  assign do_read = axi_req_i.arvalid & ~rvalid;

  always_comb begin
    axi_rsp_o.awready = ~aw_got & ~bvalid;
    axi_rsp_o.wready = ~w_got & ~bvalid;
    axi_rsp_o.bvalid = bvalid;
    axi_rsp_o.bresp = bresp;
    axi_rsp_o.arready = ~rvalid;
    axi_rsp_o.rvalid = rvalid;
    axi_rsp_o.rdata = rdata;
    axi_rsp_o.rresp = rresp;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (axi_req_i.awvalid && !aw_got && !bvalid) begin
        aw_got <= 1'b1;
        wr_addr <= axi_req_i.awaddr;
      end
      if (axi_req_i.wvalid && !w_got && !bvalid) begin
        w_got <= 1'b1;
        wr_data <= axi_req_i.wdata;
        wr_strb <= axi_req_i.wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
    end
  end

  always_comb begin
    case (wr_addr)
      OFS_RUN, OFS_MODE, OFS_CMP0, OFS_CMP1, OFS_IRQ_STATUS,
      OFS_IRQ_MASK: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req_i.bready) begin
      bvalid <= 1'b0;
    end
  end

  // Run bits 1, 4 and 5 read as zero and spare bit 6 reads back as written; software must not depend on them. [R3]
  always_comb begin
    next_rdata = '0;
    rd_known = 1'b1;
    case (axi_req_i.araddr)
      OFS_RUN: begin
        next_rdata[RUN_COUNTER_BIT] = run_reg[RUN_COUNTER_BIT];
        next_rdata[RUN_PRESCALER_BIT] = run_reg[RUN_PRESCALER_BIT];
        next_rdata[RUN_IDLE_BIT] = run_reg[RUN_IDLE_BIT];
        next_rdata[RUN_SPARE_BIT] = run_reg[RUN_SPARE_BIT];
        next_rdata[RUN_DBUF_BIT] = run_reg[RUN_DBUF_BIT];
      end
      OFS_MODE: begin
        next_rdata[7:0] = mode_reg & MODE_KEEP_MASK;
        next_rdata[MODE_SWCAP_BIT] = 1'b1;
      end
      OFS_CMP0: next_rdata[COUNT_W-1:0] = compare0_buffer;
      OFS_CMP1: next_rdata[COUNT_W-1:0] = compare_register_1;
      OFS_CAP0_LO: next_rdata[7:0] = capture_register_0[7:0];
      OFS_CAP0_HI: next_rdata[7:0] = capture_register_0[COUNT_W-1:8];
      OFS_CAP1_LO: next_rdata[7:0] = capture_register_1[7:0];
      OFS_CAP1_HI: next_rdata[7:0] = capture_register_1[COUNT_W-1:8];
      OFS_COUNT: next_rdata[COUNT_W-1:0] = up_counter;
      OFS_IRQ_STATUS: next_rdata[NUM_EVENTS-1:0] = irq_status;
      OFS_IRQ_MASK: next_rdata[NUM_EVENTS-1:0] = irq_mask;
      default: rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (do_read) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req_i.rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Control registers
  logic wr_run;
  logic wr_mode;
  logic sw_capture;

  assign wr_run = do_write && wr_addr == OFS_RUN && wr_strb[0];
  assign wr_mode = do_write && wr_addr == OFS_MODE && wr_strb[0];
  // A zero in the software capture bit is the capture command. [R10]
  assign sw_capture = wr_mode && !wr_data[MODE_SWCAP_BIT];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_reg <= RUN_RESET;
    end else if (wr_run) begin
      run_reg <= wr_data[7:0];
    end
  end

  // The top two bits are stored as zero whatever is written. [R11]
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_reg <= MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= wr_data[7:0] & MODE_KEEP_MASK;
    end
  end

  logic counter_run_bit;
  logic prescaler_run_bit;
  logic idle_run_enable;
  logic double_buffer_enable;
  logic counter_clear_enable;
  logic [1:0] clock_source_sel;
  logic [1:0] capture_trigger_sel;

  assign counter_run_bit = run_reg[RUN_COUNTER_BIT];
  assign prescaler_run_bit = run_reg[RUN_PRESCALER_BIT];
  assign idle_run_enable = run_reg[RUN_IDLE_BIT];
  assign double_buffer_enable = run_reg[RUN_DBUF_BIT];
  assign counter_clear_enable = mode_reg[MODE_CLEAR_BIT];
  assign clock_source_sel = mode_reg[MODE_CLK_LO +: 2];
  assign capture_trigger_sel = mode_reg[MODE_CAP_LO +: 2];

  // ==========================================================================
  // Prescaler and clock source
  logic awake;
  logic pre_tick;
  logic tap_div1;
  logic tap_div4;
  logic tap_div16;
  logic count_tick;

  // Idle halts the prescaler and counter unless the idle bit keeps them alive. [R2]
  assign awake = ~idle_i | idle_run_enable;
  assign pre_tick = prescaler_run_bit & awake;

  // The prescaler ignores the counter run bit entirely. [R12]
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prescaler <= '0;
    end else if (!prescaler_run_bit) begin
      prescaler <= '0;
    end else if (pre_tick) begin
      prescaler <= prescaler + 1'b1;
    end
  end

  assign tap_div1 = pre_tick;
  assign tap_div4 = pre_tick && (prescaler & DIV4_MASK) == DIV4_MASK;
  assign tap_div16 = pre_tick && prescaler == DIV16_MASK;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      in0_prev <= 1'b0;
      in1_prev <= 1'b0;
      other_prev <= 1'b0;
    end else begin
      in0_prev <= external_input_0_i;
      in1_prev <= external_input_1_i;
      other_prev <= other_timer_flipflop_out_i;
    end
  end

  always_comb begin
    case (clock_source_sel) // [R4]
      CLK_EXT: count_tick = awake & rose(in0_prev, external_input_0_i);
      CLK_DIV1: count_tick = tap_div1;
      CLK_DIV4: count_tick = tap_div4;
      CLK_DIV16: count_tick = tap_div16;
      default: count_tick = 1'b0;
    endcase
  end

  // ==========================================================================
  // Up-counter, comparators and compare registers
  logic match0;
  logic match1;
  logic clear_on_match;
  logic counter_cleared;
  logic [COUNT_W-1:0] cmp_wdata;
  logic wr_cmp0;
  logic wr_cmp1;

  // Matches count only on a tick, so a held count gives one event. [R16]
  assign match0 = counter_run_bit & count_tick &
                  (up_counter == compare_register_0);
  assign match1 = counter_run_bit & count_tick &
                  (up_counter == compare_register_1);
  assign clear_on_match = match1 & counter_clear_enable; // [R5] [R13]
  assign counter_cleared = clear_on_match | ~counter_run_bit;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      up_counter <= '0;
    end else if (!counter_run_bit) begin
      up_counter <= '0; // [R1]
    end else if (clear_on_match) begin
      up_counter <= '0; // [R5]
    end else if (count_tick) begin
      up_counter <= up_counter + 1'b1; // [R1]
    end
  end

  assign cmp_wdata = wr_data[COUNT_W-1:0];
  assign wr_cmp0 = do_write && wr_addr == OFS_CMP0 && (&wr_strb[1:0]);
  assign wr_cmp1 = do_write && wr_addr == OFS_CMP1 && (&wr_strb[1:0]);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      compare_register_1 <= '0;
    end else if (wr_cmp1) begin
      compare_register_1 <= cmp_wdata;
    end
  end

  // With buffering on, the live compare-0 value changes only at a clear.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      compare0_buffer <= '0;
      compare_register_0 <= '0;
    end else begin
      if (wr_cmp0) begin
        compare0_buffer <= cmp_wdata;
      end
      if (wr_cmp0 && !double_buffer_enable) begin
        compare_register_0 <= cmp_wdata;
      end else if (double_buffer_enable && counter_cleared) begin
        compare_register_0 <= compare0_buffer; // [R19]
      end
    end
  end

  // ==========================================================================
  // Capture logic
  logic hw_cap0;
  logic hw_cap1;
  logic take_cap0;
  logic take_cap1;
  logic rd_cap0_lo;
  logic rd_cap0_hi;
  logic rd_cap1_lo;
  logic rd_cap1_hi;

  always_comb begin
    hw_cap0 = 1'b0;
    hw_cap1 = 1'b0;
    case (capture_trigger_sel)
      CAP_OFF: begin
        hw_cap0 = 1'b0; // [R6]
        hw_cap1 = 1'b0;
      end
      CAP_IN0_IN1: begin
        hw_cap0 = rose(in0_prev, external_input_0_i); // [R7]
        hw_cap1 = rose(in1_prev, external_input_1_i);
      end
      CAP_IN0_BOTH: begin
        hw_cap0 = rose(in0_prev, external_input_0_i); // [R8]
        hw_cap1 = fell(in0_prev, external_input_0_i);
      end
      CAP_OTHER: begin
        hw_cap0 = rose(other_prev, other_timer_flipflop_out_i); // [R9]
        hw_cap1 = fell(other_prev, other_timer_flipflop_out_i);
      end
      default: begin
        hw_cap0 = 1'b0;
        hw_cap1 = 1'b0;
      end
    endcase
  end

  // A stopped prescaler freezes hardware captures, as software is told to avoid.
  assign take_cap0 = ~cap0_locked &
                     ((hw_cap0 & prescaler_run_bit) | sw_capture); // [R18]
  assign take_cap1 = ~cap1_locked & hw_cap1 & prescaler_run_bit;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      capture_register_0 <= '0;
      capture_register_1 <= '0;
    end else begin
      if (take_cap0) begin
        capture_register_0 <= up_counter; // [R10]
      end
      if (take_cap1) begin
        capture_register_1 <= up_counter;
      end
    end
  end

  assign rd_cap0_lo = do_read && axi_req_i.araddr == OFS_CAP0_LO;
  assign rd_cap0_hi = do_read && axi_req_i.araddr == OFS_CAP0_HI;
  assign rd_cap1_lo = do_read && axi_req_i.araddr == OFS_CAP1_LO;
  assign rd_cap1_hi = do_read && axi_req_i.araddr == OFS_CAP1_HI;

  // Locks keep the two halves of a capture coherent across byte reads.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cap0_locked <= 1'b0;
      cap1_locked <= 1'b0;
    end else begin
      if (rd_cap0_lo) begin
        cap0_locked <= 1'b1; // [R17]
      end else if (rd_cap0_hi) begin
        cap0_locked <= 1'b0; // [R17]
      end
      if (rd_cap1_lo) begin
        cap1_locked <= 1'b1;
      end else if (rd_cap1_hi) begin
        cap1_locked <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interrupts
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_EVENTS-1:0] status_clear;
  logic wr_status;

  assign events[EV_CMP0] = match0;
  assign events[EV_CMP1] = match1;
  assign events[EV_CAP0] = take_cap0;
  assign events[EV_CAP1] = take_cap1;
  assign wr_status = do_write && wr_addr == OFS_IRQ_STATUS && wr_strb[0];
  assign status_clear = wr_status ? wr_data[NUM_EVENTS-1:0] : '0;

  // A new event in the clearing cycle keeps its bit set.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_status
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          irq_status[gi] <= 1'b0;
        end else if (events[gi]) begin
          irq_status[gi] <= 1'b1;
        end else if (status_clear[gi]) begin
          irq_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_mask <= '0;
    end else if (do_write && wr_addr == OFS_IRQ_MASK && wr_strb[0]) begin
      irq_mask <= wr_data[NUM_EVENTS-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      compare0_interrupt_o <= 1'b0;
      compare1_interrupt_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      compare0_interrupt_o <= match0; // [R16]
      compare1_interrupt_o <= match1; // [R13]
      irq_o <= |(irq_status & irq_mask);
    end
  end

endmodule

// ==== tb/test_trmc_timer.sv ====
// Self-checking bench for the timer channel over its AXI4-Lite port.
// Assumes the package register map and a single 125 MHz clock.
`timescale 1ns/1ps
module test_trmc_timer;
  import trmc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  trmc_axil_req_t req = '0;
  trmc_axil_rsp_t rsp;
  logic in0 = 1'b0;
  logic in1 = 1'b0;
  logic oth = 1'b0;
  logic idle = 1'b0;
  logic cmp0_irq;
  logic cmp1_irq;
  logic irq;
  logic ext_run = 1'b0;
  logic [1:0] ph = 2'h0;
  logic [31:0] rd;
  logic [1:0] rr;
  int mismatches = 0;
  int num_checks = 0;
  always #4 clk_i = ~clk_i;
  // The pin clock rises once every four cycles while enabled.
  always @(posedge clk_i) ph <= ph + 2'h1;
  trmc_timer #(.COUNT_W(16)) u_trmc_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .axi_req_i(req),
    .axi_rsp_o(rsp),
    .external_input_0_i(ext_run ? ph[1] : in0),
    .external_input_1_i(in1),
    .other_timer_flipflop_out_i(oth),
    .idle_i(idle),
    .compare0_interrupt_o(cmp0_irq),
    .compare1_interrupt_o(cmp1_irq),
    .irq_o(irq)
  );
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    $display("BAD t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
    print_verdict();
  endtask
  // Ready is looked at mid-cycle; it cannot move before the next edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w, ra, rw, got;
    @(posedge clk_i);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    got = 1'b0;
    for (int i = 0; i < 50 && !got; i++) begin
      @(negedge clk_i);
      ra = rsp.awready;
      rw = rsp.wready;
      got = rsp.bvalid && !aw && !w;
      rr = rsp.bresp;
      @(posedge clk_i);
      if (ra) aw = 1'b0;
      if (rw) w = 1'b0;
      req.awvalid <= aw;
      req.wvalid <= w;
    end
    req.bready <= 1'b0;
    if (!got) give_up();
  endtask
  task automatic rd_reg(input logic [7:0] a);
    bit ar, ra, got;
    @(posedge clk_i);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    ar = 1'b1;
    got = 1'b0;
    for (int i = 0; i < 50 && !got; i++) begin
      @(negedge clk_i);
      ra = rsp.arready;
      got = rsp.rvalid && !ar;
      rd = rsp.rdata;
      rr = rsp.rresp;
      @(posedge clk_i);
      if (ra) ar = 1'b0;
      req.arvalid <= ar;
    end
    req.rready <= 1'b0;
    if (!got) give_up();
  endtask
  task automatic rdcap(input logic [7:0] lo, output logic [15:0] v);
    rd_reg(lo);
    v[7:0] = rd[7:0];
    rd_reg(lo + 8'h04);
    v[15:8] = rd[7:0];
  endtask
  // Cycles from one compare pulse to the next.
  task automatic period(input bit s, output int n);
    n = 0;
    for (int i = 0; i < 1000 && !(s ? cmp1_irq : cmp0_irq); i++)
      @(negedge clk_i);
    do begin
      @(negedge clk_i);
      n++;
    end while (!(s ? cmp1_irq : cmp0_irq) && n < 1000);
    if (n >= 1000) give_up();
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd_reg(OFS_RUN);
    check(32'(RUN_RESET), rd);
    rd_reg(OFS_MODE);
    check(32'h21, rd);
    wr(OFS_RUN, 32'hbf);
    rd_reg(OFS_RUN);
    check(32'h8d, rd);
    wr(OFS_RUN, 32'h0);
    wr(8'h30, 32'h1);
    check(32'(RESP_SLVERR), 32'(rr));
    rd_reg(8'h30);
    check(32'(RESP_SLVERR), 32'(rr));
  endtask
  task automatic t_interval();
    logic [1:0] src [4] = '{CLK_EXT, CLK_DIV1, CLK_DIV4, CLK_DIV16};
    int dv [4] = '{4, 1, 4, 16};
    int n;
    wr(OFS_CMP0, 32'h1);
    wr(OFS_CMP1, 32'h3);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_RUN, 32'h0);
      ext_run <= (k == 0);
      wr(OFS_MODE, {24'h0, 2'h0, CAP_OFF, 1'b1, src[k], 1'b1});
      wr(OFS_RUN, 32'h5);
      period(1'b1, n);
      check(4 * dv[k], n);
    end
    in0 <= 1'b0;
    period(1'b0, n);
    check(32'd64, n);
    wr(OFS_RUN, 32'h0);
    rd_reg(OFS_IRQ_STATUS);
    check(32'h3, rd);
    check(32'h0, irq);
    wr(OFS_IRQ_MASK, 32'h2);
    @(negedge clk_i);
    check(32'h1, irq);
    wr(OFS_IRQ_STATUS, 32'h2);
    @(negedge clk_i);
    check(32'h0, irq);
  endtask
  task automatic t_run();
    logic [15:0] a;
    rd_reg(OFS_COUNT);
    check(32'h0, rd);
    wr(OFS_RUN, 32'h1);
    rd_reg(OFS_COUNT);
    check(32'h0, rd);
    wr(OFS_MODE, 32'h3);
    wr(OFS_RUN, 32'h5);
    rd_reg(OFS_COUNT);
    rd_reg(OFS_COUNT);
    check(32'h1, 32'(rd > 32'h3));
    idle <= 1'b1;
    rd_reg(OFS_COUNT);
    a = rd[15:0];
    rd_reg(OFS_COUNT);
    check(32'(a), rd);
    wr(OFS_RUN, 32'h0d);
    rd_reg(OFS_COUNT);
    a = rd[15:0];
    rd_reg(OFS_COUNT);
    check(32'h1, 32'(rd[15:0] != a));
    idle <= 1'b0;
  endtask
  task automatic t_cap(input logic [1:0] m, input int gap,
                       output logic [15:0] c0, output logic [15:0] c1);
    wr(OFS_MODE, {24'h0, 2'h0, m, 4'h3});
    @(posedge clk_i);
    if (m == CAP_OTHER) oth <= 1'b1;
    else in0 <= 1'b1;
    repeat (gap) @(posedge clk_i);
    case (m)
      CAP_IN0_IN1: in1 <= 1'b1;
      CAP_OTHER: oth <= 1'b0;
      default: in0 <= 1'b0;
    endcase
    @(posedge clk_i);
    in0 <= 1'b0;
    in1 <= 1'b0;
    oth <= 1'b0;
    rdcap(OFS_CAP0_LO, c0);
    rdcap(OFS_CAP1_LO, c1);
  endtask
  task automatic t_captures();
    logic [15:0] a, b, c, d;
    t_cap(CAP_IN0_IN1, 5, a, b);
    check(32'd5, 32'(16'(b - a)));
    t_cap(CAP_IN0_BOTH, 7, a, b);
    check(32'd7, 32'(16'(b - a)));
    t_cap(CAP_OTHER, 9, a, b);
    check(32'd9, 32'(16'(b - a)));
    t_cap(CAP_OFF, 11, c, d);
    check(32'(a), 32'(c));
    check(32'(b), 32'(d));
    // A held low byte must keep its partner high byte from moving.
    rd_reg(OFS_CAP0_LO);
    wr(OFS_MODE, 32'h2);
    rd_reg(OFS_CAP0_HI);
    rdcap(OFS_CAP0_LO, c);
    check(32'(a), 32'(c));
    wr(OFS_MODE, 32'h3);
    rdcap(OFS_CAP0_LO, c);
    check(32'(a), 32'(c));
    wr(OFS_MODE, 32'h2);
    rdcap(OFS_CAP0_LO, c);
    check(32'h1, 32'(c != a));
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_interval();
    t_run();
    t_captures();
    print_verdict();
  end
endmodule

// ==== tb/trmc_timer_chk.sv ====
// Checker for the timer channel: bus handshakes and read-back fields.
// Assumes it is bound to trmc_timer and sees only that module's ports.
`timescale 1ns/1ps
module trmc_chk #(
  parameter int COUNT_W = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire trmc_pkg::trmc_axil_req_t axi_req_i,
  input wire trmc_pkg::trmc_axil_rsp_t axi_rsp_o,
  input wire logic external_input_0_i,
  input wire logic external_input_1_i,
  input wire logic other_timer_flipflop_out_i,
  input wire logic idle_i,
  input wire logic compare0_interrupt_o,
  input wire logic compare1_interrupt_o,
  input wire logic irq_o
);
  import trmc_pkg::*;
  // ==========================================================================
  // Helper logic
  logic [AXI_ADDR_W-1:0] last_ar;
  logic ar_take;
  logic w_take;
  assign ar_take = axi_req_i.arvalid && axi_rsp_o.arready;
  assign w_take = axi_req_i.awvalid && axi_rsp_o.awready &&
                  axi_req_i.wvalid && axi_rsp_o.wready;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      last_ar <= '0;
    end else if (ar_take) begin
      last_ar <= axi_req_i.araddr;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================================
  // Properties
  property p_ar_answer;
    ar_take |=> axi_rsp_o.rvalid;
  endproperty
  property p_arready;
    axi_rsp_o.arready == !axi_rsp_o.rvalid;
  endproperty
  property p_r_hold;
    axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid &&
      $stable(axi_rsp_o.rdata) && $stable(axi_rsp_o.rresp);
  endproperty
  property p_b_after;
    w_take |-> ##2 axi_rsp_o.bvalid;
  endproperty
  property p_b_hold;
    axi_rsp_o.bvalid && !axi_req_i.bready |=>
      axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp);
  endproperty
  property p_refuse;
    axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready;
  endproperty
  property p_run_rd;
    axi_rsp_o.rvalid && last_ar == OFS_RUN |->
      axi_rsp_o.rdata[5:4] == 2'h0 && !axi_rsp_o.rdata[1];
  endproperty
  property p_mode_rd;
    axi_rsp_o.rvalid && last_ar == OFS_MODE |->
      axi_rsp_o.rdata[7:6] == 2'h0 && axi_rsp_o.rdata[0];
  endproperty
  property p_unmapped;
    ar_take && axi_req_i.araddr > OFS_IRQ_MASK |=>
      axi_rsp_o.rresp == RESP_SLVERR && axi_rsp_o.rdata == '0;
  endproperty
  property p_mapped;
    ar_take && axi_req_i.araddr <= OFS_IRQ_MASK |=>
      axi_rsp_o.rresp == RESP_OKAY;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("no read answer");
  a_arready: assert property (p_arready) else $error("arready wrong");
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  a_b_after: assert property (p_b_after) else $error("no write answer");
  a_b_hold: assert property (p_b_hold) else $error("write answer moved");
  a_refuse: assert property (p_refuse) else $error("write taken early");
  a_run_rd: assert property (p_run_rd) else $error("run bits wrong");
  a_mode_rd: assert property (p_mode_rd) else $error("mode bits bad");
  a_unmapped: assert property (p_unmapped) else $error("bad addr read");
  a_mapped: assert property (p_mapped) else $error("good addr refused");
  c_write: cover property (w_take);
  c_unmapped: cover property (ar_take && axi_req_i.araddr > OFS_IRQ_MASK);
  c_match: cover property (compare1_interrupt_o);
  c_irq: cover property (irq_o);
endmodule

bind trmc_timer trmc_chk #(.COUNT_W(COUNT_W)) u_trmc_chk (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .axi_req_i(axi_req_i),
  .axi_rsp_o(axi_rsp_o),
  .external_input_0_i(external_input_0_i),
  .external_input_1_i(external_input_1_i),
  .other_timer_flipflop_out_i(other_timer_flipflop_out_i),
  .idle_i(idle_i),
  .compare0_interrupt_o(compare0_interrupt_o),
  .compare1_interrupt_o(compare1_interrupt_o),
  .irq_o(irq_o)
);
